// [core/exec_pkg.sv]
// Shared types and constants for the shifter and status-transfer datapath
// Contract
// - Register shift amount uses low byte only
// - Register amount zero passes operand, old carry
// - Register amounts 1-31 match encoded shifts
// - Left shift 32 gives zero, carry bit0
// - Right shift 32 gives zero, carry bit31
// - Arithmetic shift 32+ fills with sign bit
// - Rotate 32 keeps operand; larger wraps modulo
// - Register shift with bit7 set is multiply/undefined
// - Immediate rotated right by twice rotate field
// - Non-PC destination updates flags when set-flags
// - PC destination without set-flags keeps status
// - PC destination with set-flags restores saved status
// - PC operand reads address plus 8 or 12
// - Test/compare opcodes set flags, write nothing
// - Legacy restore copies saved status when privileged
// - Test opcodes without set-flags are status transfers
// - Status transfers move status to/from registers
// - Flags-only transfer writes bits 31:28 only
// - User mode changes only the condition flags
// - Saved status banked per active privileged mode
// - Status holds flags, interrupt masks, mode bits
// - Logical ops: carry from shifter, overflow kept
// - Arithmetic ops: overflow and carry from bit31
// - Rotate-extend rotates carry-plus-operand by one
package exec_pkg;

	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;
	localparam int BANK_COUNT = 5;

	localparam logic [3:0] PC_INDEX = 4'hf;
	localparam logic [31:0] PC_OFFSET_IMM = 32'h8;
	localparam logic [31:0] PC_OFFSET_REG = 32'hc;

	localparam logic [7:0] SHIFT_FULL = 8'h20;
	localparam logic [31:0] STATUS_DEFINED = 32'hf00000df;
	localparam logic [31:0] STATUS_FLAGS = 32'hf0000000;
	localparam logic [31:0] STATUS_RESET = 32'h000000d3;

	typedef enum logic [1:0] {
		SH_LSL = 2'h0,
		SH_LSR = 2'h1,
		SH_ASR = 2'h2,
		SH_ROR = 2'h3
	} shift_kind_t;

	typedef enum logic [3:0] {
		OP_AND = 4'h0, OP_EOR = 4'h1, OP_SUB = 4'h2, OP_RSB = 4'h3,
		OP_ADD = 4'h4, OP_ADC = 4'h5, OP_SBC = 4'h6, OP_RSC = 4'h7,
		OP_TST = 4'h8, OP_TEQ = 4'h9, OP_CMP = 4'ha, OP_CMN = 4'hb,
		OP_ORR = 4'hc, OP_MOV = 4'hd, OP_BIC = 4'he, OP_MVN = 4'hf
	} alu_op_t;

	typedef struct packed {
		logic [4:0] amount;
		shift_kind_t kind;
		logic by_reg;
		logic [3:0] rm;
	} shift_op_t;

	typedef struct packed {
		logic [3:0] cond;
		logic [1:0] cls;
		logic imm;
		alu_op_t opcode;
		logic set_flags;
		logic [3:0] rn;
		logic [3:0] rd;
		shift_op_t op2;
	} instr_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
		logic [19:0] rsv_hi;
		logic irq_off;
		logic fiq_off;
		logic rsv_lo;
		logic [4:0] mode;
	} status_t;

	typedef struct packed {
		logic [31:0] first;
		logic [31:0] shifted;
		logic [31:0] count;
		logic [31:0] addr;
	} operands_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] dest;
		logic reg_write;
		logic pc_write;
	} writeback_t;

endpackage

// [core/barrel_shift.sv]
// Barrel shifter for encoded and register-supplied shift amounts
module barrel_shift (
	input wire logic [31:0] value_in,
	input wire exec_pkg::shift_kind_t kind_in,
	input wire logic [7:0] amount_in,
	input wire logic by_reg_in,
	input wire logic carry_in,
	output logic [31:0] result_out,
	output logic carry_out
);
	import exec_pkg::*;

	logic [7:0] eff;
	logic [32:0] wide;
	logic [4:0] red;

	always_comb begin
		eff = amount_in;
		wide = 33'h0;
		red = amount_in[4:0];
		result_out = value_in;
		carry_out = carry_in;
		if (!by_reg_in && amount_in == 8'h0 && kind_in != SH_LSL) begin
			eff = SHIFT_FULL;
		end
		if (eff == 8'h0) begin
			result_out = value_in;
			carry_out = carry_in;
		end else if (!by_reg_in && amount_in == 8'h0 && kind_in == SH_ROR) begin
			result_out = {carry_in, value_in[31:1]};
			carry_out = value_in[0];
		end else begin
			unique case (kind_in)
				SH_LSL: begin
					wide = {1'b0, value_in} << eff[4:0];
					result_out = (eff < SHIFT_FULL) ? wide[31:0] : 32'h0;
					if (eff < SHIFT_FULL) carry_out = wide[32];
					else carry_out = (eff == SHIFT_FULL) & value_in[0];
				end
				SH_LSR: begin
					wide = {value_in, 1'b0} >> eff[4:0];
					result_out = (eff < SHIFT_FULL) ? wide[32:1] : 32'h0;
					if (eff < SHIFT_FULL) carry_out = wide[0];
					else carry_out = (eff == SHIFT_FULL) & value_in[31];
				end
				SH_ASR: begin
					wide = 33'($signed({value_in, 1'b0}) >>> eff[4:0]);
					if (eff < SHIFT_FULL) begin
						result_out = wide[32:1];
						carry_out = wide[0];
					end else begin
						result_out = {32{value_in[31]}};
						carry_out = value_in[31];
					end
				end
				SH_ROR: begin
					red = eff[4:0];
					result_out = (value_in >> red) | (value_in << (6'd32 - {1'b0, red}));
					carry_out = result_out[31];
				end
			endcase
		end
	end

endmodule

// [core/saved_bank.sv]
// Banked saved-status storage, one word per privileged mode
module saved_bank #(
	parameter int DEPTH = 5,
	parameter int WIDTH = 32
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic write_in,
	input wire logic [2:0] write_index_in,
	input wire logic [WIDTH-1:0] write_data_in,
	input wire logic [2:0] read_index_in,
	output logic [WIDTH-1:0] read_data_out
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int k = 0; k < DEPTH; k++) begin
				mem[k] <= '0;
			end
		end else if (write_in && int'(write_index_in) < DEPTH) begin
			mem[write_index_in] <= write_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			read_data_out <= '0;
		end else if (int'(read_index_in) < DEPTH) begin
			read_data_out <= mem[read_index_in];
		end else begin
			read_data_out <= '0;
		end
	end

endmodule

// [core/exec_unit.sv]
// Data-processing execute stage with status-register transfers
module exec_unit (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic valid_in,
	input wire exec_pkg::instr_t instr_in,
	input wire exec_pkg::operands_t operands_in,
	output logic ready_out,
	output logic done_out,
	output logic undef_out,
	output exec_pkg::writeback_t wb_out,
	output exec_pkg::status_t status_out
);
	import exec_pkg::*;

	typedef enum logic {ST_IDLE, ST_EXEC} state_t;

	state_t state;
	instr_t ins;
	operands_t ops;
	status_t cs;
	logic [31:0] saved_rd;

	logic [31:0] pc_val;
	logic [31:0] first_val;
	logic [31:0] rm_val;
	logic [7:0] sh_amount;
	logic [31:0] sh_result;
	logic sh_carry;
	logic [31:0] imm_val;
	logic [31:0] op2;
	logic op2_carry;
	logic [31:0] alu_res;
	logic alu_c;
	logic alu_v;
	logic [32:0] sum;
	logic [31:0] ax;
	logic [31:0] ay;
	logic acin;
	logic is_mul_undef;
	logic is_test;
	logic is_xfer;
	logic is_data;
	logic privileged;
	logic has_saved;
	logic [2:0] cur_bank;
	logic [3:0] bank_code;
	logic bank_we;
	logic [31:0] bank_wdata;
	logic [31:0] next_cs;
	logic [31:0] xfer_src;
	logic [31:0] xfer_mask;

	function automatic logic [3:0] bank_of(input logic [4:0] mode);
		unique case (mode)
			MODE_FIQ: bank_of = 4'h8;
			MODE_IRQ: bank_of = 4'h9;
			MODE_SVC: bank_of = 4'ha;
			MODE_ABT: bank_of = 4'hb;
			MODE_UND: bank_of = 4'hc;
			default: bank_of = 4'h0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] upd, input logic [31:0] mask);
		merge = (old & ~mask) | (upd & mask & STATUS_DEFINED);
	endfunction

	function automatic logic is_arith(input alu_op_t op);
		is_arith = (op inside {OP_SUB, OP_RSB, OP_ADD, OP_ADC,
			OP_SBC, OP_RSC, OP_CMP, OP_CMN});
	endfunction

	// Saved-status bank for the mode active now
	assign bank_code = bank_of(cs.mode);
	assign cur_bank = bank_code[2:0];
	assign has_saved = bank_code[3];
	assign privileged = (cs.mode != MODE_USER);

	saved_bank #(
		.DEPTH(BANK_COUNT),
		.WIDTH(32)
	) u_bank (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.write_in(bank_we),
		.write_index_in(cur_bank),
		.write_data_in(bank_wdata),
		.read_index_in(cur_bank),
		.read_data_out(saved_rd)
	);

	assign ready_out = (state == ST_IDLE);

	// Sequencer: accept in idle, execute in the following cycle
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: if (valid_in) state <= ST_EXEC;
				ST_EXEC: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ins <= '0;
			ops <= '0;
		end else if (state == ST_IDLE && valid_in) begin
			ins <= instr_in;
			ops <= operands_in;
		end
	end

	// Decode of instruction class
	always_comb begin
		is_mul_undef = !ins.imm && ins.op2.by_reg && ins.op2.amount[0];
		is_test = (ins.opcode[3:2] == 2'b10) && ins.set_flags;
		is_xfer = (ins.opcode[3:2] == 2'b10) && !ins.set_flags;
		is_data = !is_mul_undef && !is_test && !is_xfer;
	end

	// Operand fetch with prefetch offset on the program counter
	always_comb begin
		pc_val = ops.addr + ((!ins.imm && ins.op2.by_reg) ?
			PC_OFFSET_REG : PC_OFFSET_IMM);
		first_val = (ins.rn == PC_INDEX) ? pc_val : ops.first;
		rm_val = (ins.op2.rm == PC_INDEX) ? pc_val : ops.shifted;
		sh_amount = ins.op2.by_reg ? ops.count[7:0] :
			{3'h0, ins.op2.amount};
	end

	barrel_shift u_shift (
		.value_in(rm_val),
		.kind_in(ins.op2.kind),
		.amount_in(sh_amount),
		.by_reg_in(ins.op2.by_reg),
		.carry_in(cs.c),
		.result_out(sh_result),
		.carry_out(sh_carry)
	);

	// Second operand: rotated immediate or shifted register
	always_comb begin
		imm_val = {24'h0, ins.op2[7:0]};
		imm_val = (imm_val >> {ins.op2[11:8], 1'b0}) |
			(imm_val << (6'd32 - {1'b0, ins.op2[11:8], 1'b0}));
		if (ins.imm) begin
			op2 = imm_val;
			op2_carry = (ins.op2[11:8] == 4'h0) ? cs.c : imm_val[31];
		end else begin
			op2 = sh_result;
			op2_carry = sh_carry;
		end
	end

	// Adder operand selection and logic results
	always_comb begin
		ax = first_val;
		ay = op2;
		acin = 1'b0;
		unique case (ins.opcode)
			OP_SUB, OP_CMP: begin
				ay = ~op2;
				acin = 1'b1;
			end
			OP_RSB: begin
				ax = op2;
				ay = ~first_val;
				acin = 1'b1;
			end
			OP_ADC: acin = cs.c;
			OP_SBC: begin
				ay = ~op2;
				acin = cs.c;
			end
			OP_RSC: begin
				ax = op2;
				ay = ~first_val;
				acin = cs.c;
			end
			default: acin = 1'b0;
		endcase
		sum = {1'b0, ax} + {1'b0, ay} + {32'h0, acin};
		unique case (ins.opcode)
			OP_AND, OP_TST: alu_res = first_val & op2;
			OP_EOR, OP_TEQ: alu_res = first_val ^ op2;
			OP_ORR: alu_res = first_val | op2;
			OP_MOV: alu_res = op2;
			OP_BIC: alu_res = first_val & ~op2;
			OP_MVN: alu_res = ~op2;
			default: alu_res = sum[31:0];
		endcase
		if (is_arith(ins.opcode)) begin
			alu_c = sum[32];
			alu_v = (ax[31] == ay[31]) && (sum[31] != ax[31]);
		end else begin
			alu_c = op2_carry;
			alu_v = cs.v;
		end
	end

	// Status transfer source and write mask
	always_comb begin
		xfer_src = ins.imm ? imm_val : ops.shifted;
		if (!ins.rn[0]) begin
			xfer_mask = STATUS_FLAGS;
		end else begin
			xfer_mask = STATUS_DEFINED;
		end
	end

	// Next value of the current status register
	always_comb begin
		next_cs = cs;
		bank_we = 1'b0;
		bank_wdata = saved_rd;
		if (state == ST_EXEC) begin
			if (is_data && ins.rd == PC_INDEX) begin
				if (ins.set_flags && has_saved) begin
					next_cs = saved_rd & STATUS_DEFINED;
				end
			end else if (is_test && ins.rd == PC_INDEX &&
				ins.opcode == OP_TEQ) begin
				if (privileged && has_saved) begin
					next_cs = saved_rd & STATUS_DEFINED;
				end
			end else if (is_data || is_test) begin
				if (ins.set_flags) begin
					next_cs[31:28] = {alu_res[31], alu_res == 32'h0,
						alu_c, alu_v};
				end
			end else if (is_xfer && ins.opcode[0]) begin
				if (!ins.opcode[1]) begin
					next_cs = merge(cs, xfer_src, privileged ?
						xfer_mask : STATUS_FLAGS);
				end else if (has_saved) begin
					bank_we = 1'b1;
					bank_wdata = merge(saved_rd, xfer_src, xfer_mask);
				end
			end
		end
	end

	// Current status register, privileged supervisor mode after reset
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cs <= STATUS_RESET;
		end else begin
			cs <= next_cs & STATUS_DEFINED;
		end
	end

	assign status_out = cs;

	// Writeback of result or status copy
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wb_out <= '0;
			done_out <= 1'b0;
			undef_out <= 1'b0;
		end else begin
			done_out <= (state == ST_EXEC);
			undef_out <= (state == ST_EXEC) && is_mul_undef;
			wb_out.reg_write <= 1'b0;
			wb_out.pc_write <= 1'b0;
			if (state == ST_EXEC) begin
				wb_out.dest <= ins.rd;
				if (is_data) begin
					wb_out.data <= alu_res;
					wb_out.reg_write <= (ins.rd != PC_INDEX);
					wb_out.pc_write <= (ins.rd == PC_INDEX);
				end else if (is_xfer && !ins.opcode[0]) begin
					wb_out.data <= ins.opcode[1] ?
						(has_saved ? saved_rd : 32'h0) : cs;
					wb_out.reg_write <= 1'b1;
				end
			end
		end
	end

endmodule

// [verification/exec_unit_checker.sv]
// Port-level checks for the execute stage
module exec_checker (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic valid_in,
	input wire exec_pkg::instr_t instr_in,
	input wire logic ready_out,
	input wire logic done_out,
	input wire logic undef_out,
	input wire exec_pkg::writeback_t wb_out,
	input wire exec_pkg::status_t status_out
);
	import exec_pkg::*;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_take;
		valid_in && ready_out;
	endsequence
	sequence s_answer;
		!ready_out ##1 (ready_out && done_out);
	endsequence
	property p_timing;
		s_take |=> s_answer;
	endproperty
	property p_test;
		s_take ##0 (instr_in.opcode[3:2] == 2'h2 && instr_in.set_flags)
			|-> ##2 (done_out && !wb_out.reg_write);
	endproperty
	property p_undef;
		undef_out |-> done_out && !wb_out.reg_write && !wb_out.pc_write;
	endproperty
	property p_pcw;
		wb_out.pc_write |-> done_out && wb_out.dest == PC_INDEX;
	endproperty
	property p_rsv;
		(status_out & ~STATUS_DEFINED) == 32'h0;
	endproperty
	property p_user;
		status_out.mode == MODE_USER |=> $stable(status_out[27:0]);
	endproperty
	property p_still;
		$changed(status_out) |-> done_out;
	endproperty
	property p_busy;
		!ready_out |=> ready_out && !$stable(done_out);
	endproperty
	a_timing: assert property (p_timing) else $error("answer late");
	a_test: assert property (p_test) else $error("test wrote");
	a_undef: assert property (p_undef) else $error("undef wrote");
	a_pcw: assert property (p_pcw) else $error("bad pc write");
	a_rsv: assert property (p_rsv) else $error("reserved set");
	a_user: assert property (p_user) else $error("user ctrl");
	a_still: assert property (p_still) else $error("stray status");
	a_busy: assert property (p_busy) else $error("busy long");
endmodule

bind exec_unit exec_checker i_chk (.sys_clk_in, .resetn_in, .valid_in,
	.instr_in, .ready_out, .done_out, .undef_out, .wb_out, .status_out);

// [verification/tb_top.sv]
// Self-checking bench for the execute stage
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import exec_pkg::*;
	logic sys_clk_in = 0;
	logic resetn_in = 0;
	logic valid_in = 0;
	instr_t instr_in = '0;
	operands_t operands_in = '0;
	logic ready_out, done_out, undef_out, und;
	writeback_t wb_out, wb;
	status_t status_out;
	int err_total = 0;
	int n_checks = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	exec_unit i_dut (.sys_clk_in, .resetn_in, .valid_in, .instr_in,
		.operands_in, .ready_out, .done_out, .undef_out, .wb_out, .status_out);
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task run(input logic [3:0] op, input logic s, input logic i,
		input logic [7:0] nd, input logic [11:0] o2, input logic [31:0] a, b, c);
		instr_in = {4'he, 2'h0, i, op, s, nd, o2};
		operands_in = {a, b, c, 32'h100};
		valid_in = 1;
		@(negedge sys_clk_in);
		valid_in = 0;
		for (int k = 0; k < 8 && done_out !== 1'b1; k++) @(negedge sys_clk_in);
		if (done_out !== 1'b1) begin
			err_total++;
			end_sim;
		end
		wb = wb_out;
		und = undef_out;
	endtask
	task shf(input logic [1:0] k, input logic [31:0] n, v, r, input logic c);
		run(OP_MOV, 1, 0, 8'h01, {4'h3, 1'b0, k, 1'b1, 4'h2}, 0, v, n);
		`CHK(wb.data, r)
		`CHK({wb.reg_write, wb.pc_write, wb.dest}, 6'h21)
		`CHK(status_out.c, c)
		`CHK(status_out.z, r == 0)
	endtask
	task t_reset;
		repeat (5) @(negedge sys_clk_in);
		`CHK({ready_out, done_out, status_out}, {2'h2, STATUS_RESET})
		resetn_in = 1;
		@(negedge sys_clk_in);
	endtask
	task t_reg_shifts;
		shf(SH_LSL, 32'hab000104, 32'h18000001, 32'h80000010, 1);
		shf(SH_LSL, 32'h100, 32'h12345678, 32'h12345678, 1);
		shf(SH_LSL, 32'h20, 32'h1, 0, 1);
		shf(SH_LSL, 32'h21, 32'h1, 0, 0);
		shf(SH_LSR, 32'h20, 32'h80000000, 0, 1);
		shf(SH_LSR, 32'hff, 32'h80000000, 0, 0);
		shf(SH_ASR, 32'h4, 32'h80000010, 32'hf8000001, 0);
		shf(SH_ASR, 32'h28, 32'h80000000, 32'hffffffff, 1);
		shf(SH_ROR, 32'h20, 32'h80000001, 32'h80000001, 1);
		shf(SH_ROR, 32'h24, 32'hf, 32'hf0000000, 1);
	endtask
	task t_operands;
		run(OP_MOV, 1, 0, 8'h01, 12'h062, 0, 32'h2, 0);
		`CHK({wb.data, status_out.c}, 33'h100000002)
		run(OP_MOV, 1, 0, 8'h01, 12'h392, 0, 32'h2, 0);
		`CHK({und, wb.reg_write}, 2'h2)
		run(OP_MOV, 0, 1, 8'h01, 12'h4ff, 0, 0, 0);
		`CHK(wb.data, 32'hff000000)
		`CHK(status_out, 32'h800000d3)
		run(OP_MOV, 0, 0, 8'h01, 12'h00f, 0, 32'hdeadbeef, 0);
		`CHK(wb.data, 32'h108)
		run(OP_MOV, 0, 0, 8'h01, 12'h31f, 0, 32'hdeadbeef, 0);
		`CHK(wb.data, 32'h10c)
	endtask
	task t_tests;
		for (int j = 0; j < 4; j++) begin
			run(4'(8 + j), 1, 0, 8'h01, 12'h002, 32'h80000000,
				32'h80000000, 0);
			`CHK({wb.reg_write, status_out[31:30]}, j ? 3'h1 : 3'h2)
		end
		`CHK(status_out[29:28], 2'h3)
	endtask
	task t_xfer;
		run(OP_CMN, 0, 0, 8'h00, 12'h002, 0, 32'h9abcdef0, 0);
		run(OP_CMP, 0, 0, 8'h01, 12'h002, 0, 0, 0);
		`CHK(wb.data, 32'h90000000)
		run(OP_CMN, 0, 0, 8'h10, 12'h002, 0, 32'h60000010, 0);
		run(OP_TEQ, 0, 0, 8'h00, 12'h002, 0, 32'ha00000ff, 0);
		`CHK(status_out, 32'ha00000d3)
		run(OP_TEQ, 0, 0, 8'h10, 12'h002, 0, 32'h000000d2, 0);
		`CHK(status_out, 32'h000000d2)
		run(OP_CMN, 0, 0, 8'h10, 12'h002, 0, 32'h20000011, 0);
		run(OP_TEQ, 1, 0, 8'h0f, 12'h002, 0, 0, 0);
		`CHK(status_out, 32'h20000011)
		run(OP_TEQ, 0, 0, 8'h10, 12'h002, 0, 32'h000000d3, 0);
		run(OP_CMP, 0, 0, 8'h01, 12'h002, 0, 0, 0);
		`CHK({wb.reg_write, wb.data}, {1'b1, 32'h60000010})
	endtask
	task t_pc_dest;
		run(OP_MOV, 1, 0, 8'h0f, 12'h002, 0, 32'h1000, 0);
		`CHK({wb.reg_write, wb.pc_write, wb.data}, {2'h1, 32'h1000})
		`CHK(status_out, 32'h60000010)
		run(OP_TEQ, 0, 0, 8'h10, 12'h002, 0, 32'hf00000d3, 0);
		`CHK(status_out, 32'hf0000010)
		run(OP_TEQ, 1, 0, 8'h0f, 12'h002, 0, 0, 0);
		`CHK(status_out, 32'hf0000010)
		run(OP_MOV, 0, 0, 8'h0f, 12'h002, 0, 32'h2000, 0);
		`CHK({wb.reg_write, wb.pc_write, wb.data}, {2'h1, 32'h2000})
		`CHK(status_out, 32'hf0000010)
		run(OP_TST, 0, 0, 8'h01, 12'h002, 0, 0, 0);
		`CHK({wb.reg_write, wb.data}, {1'b1, 32'hf0000010})
	endtask
	initial begin
		t_reset;
		t_reg_shifts;
		t_operands;
		t_tests;
		t_xfer;
		t_pc_dest;
		end_sim;
	end
endmodule
